// file: core/self_polling_scheduler.sv
// Self-polling scheduler with a classic Wishbone register slave
//
// Behaviour
// - Permanent search restarts scan at list end, in constant mode only
// - Master period expiry starts next polling cycle
// - Active/idle selection suppresses chosen polling periods
// - Mode field picks constant, fast, mixed
// - Control bit 3 enables permanent search
// - Control bit 2 enables active/idle selection
// - Reference tick every 64 times divider clocks
// - Off time is 14-bit count of ticks
// - Active count zero means 256 periods
// - Idle count zero means 256 periods
// - Receiver-active pin high while receiver runs
// - Chip mode bit 0 selects pin function
// - Fast mode on time from config A timer
// - Master period is on time then off
`timescale 1ns/1ps
`include "sps_params.svh"
module self_polling_scheduler (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Scan engine status and received data
	input wire logic scan_done,
	input wire logic scan_cfg_b,
	input wire logic rx_data,
	// Scheduler outputs
	output logic rx_active,
	output logic rx_run_pin,
	output logic scan_restart,
	output logic period_start,
	output logic idle_phase
);
	import sps_pkg::*;

	// Registered state and its next value
	sched_s s_q;
	sched_s s_d;

	// Turns an 8-bit count into a length where zero means 256
	function automatic logic [8:0] len_of(input logic [7:0] v);
		begin
			len_of = (v == 8'h00) ? `LEN_ZERO_8 : {1'b0, v};
		end
	endfunction

	// Register index taken from the byte address
	logic [5:0] idx;
	// Wishbone request in progress
	logic req;
	// Write that takes effect at the acknowledging edge
	logic wr_go;
	// Lengths decoded from the registers
	logic [8:0] div_len;
	logic [8:0] on_len;
	logic [8:0] act_len;
	logic [8:0] idle_len;
	logic [14:0] off_len;
	// Timing enables
	logic tick64;
	logic ref_tick;
	logic tmr_end;
	// Decoded control fields
	logic [1:0] mode;
	logic perm_search_en;
	logic active_idle_en;
	logic run_pin_function_sel;
	logic poll_run;
	// Read data for the addressed register
	logic [31:0] rd_val;

	// Address decode and register field split
	always_comb begin
		idx = adr_i[7:2];
		req = cyc_i & stb_i;
		wr_go = req & we_i & s_q.ack & sel_i[0];
		mode = s_q.poll_ctrl[1:0];
		perm_search_en = s_q.poll_ctrl[`BIT_PERM_SEARCH];
		active_idle_en = s_q.poll_ctrl[`BIT_ACT_IDLE];
		run_pin_function_sel = s_q.chip_mode[`BIT_PIN_SEL];
		poll_run = s_q.run_ctrl[`BIT_RUN];
		div_len = len_of(s_q.ref_div);
		on_len = len_of(s_q.on_time);
		act_len = len_of(s_q.act_per & `MASK_ACT_PER);
		idle_len = len_of(s_q.idle_per);
		// Zero in the 14-bit field stands for 16384 ticks
		if ({s_q.off_high[5:0], s_q.off_low} == 14'h0000) begin
			off_len = `LEN_ZERO_OFF;
		end else begin
			off_len = {1'b0, s_q.off_high[5:0], s_q.off_low};
		end
	end

	// Reference tick: 64-clock prescaler then the 8-bit divider
	always_comb begin
		tick64 = poll_run & (s_q.pre == `PRESCALE_LAST);
		ref_tick = tick64 & ((s_q.div_cnt + `ONE_9) == div_len);
		// On and off windows count reference ticks
		if (s_q.phase == ST_ON) begin
			tmr_end = ref_tick & ((s_q.tmr_cnt + `ONE_15) == {6'h00, on_len});
		end else begin
			tmr_end = ref_tick & ((s_q.tmr_cnt + `ONE_15) == off_len);
		end
	end

	// Read multiplexer; unmapped indices read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (idx)
			`IDX_CHIP_MODE: begin
				rd_val[7:0] = s_q.chip_mode;
			end
			`IDX_POLL_CTRL: begin
				rd_val[7:0] = s_q.poll_ctrl;
			end
			`IDX_REF_DIV: begin
				rd_val[7:0] = s_q.ref_div;
			end
			`IDX_OFF_LOW: begin
				rd_val[7:0] = s_q.off_low;
			end
			`IDX_OFF_HIGH: begin
				rd_val[7:0] = s_q.off_high;
			end
			`IDX_ACT_PER: begin
				rd_val[7:0] = s_q.act_per;
			end
			`IDX_IDLE_PER: begin
				rd_val[7:0] = s_q.idle_per;
			end
			`IDX_ON_TIME: begin
				rd_val[7:0] = s_q.on_time;
			end
			`IDX_RUN_CTRL: begin
				rd_val[7:0] = s_q.run_ctrl;
			end
			`IDX_STATUS: begin
				// Live scheduler state for software
				rd_val[0] = s_q.rx_on;
				rd_val[1] = s_q.idle;
				rd_val[3:2] = s_q.phase;
				rd_val[12:4] = s_q.per_cnt;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// Next state of the whole scheduler
	always_comb begin
		s_d = s_q;
		s_d.restart = 1'b0;
		s_d.period = 1'b0;

		// Bus: one acknowledge per request, dropped the cycle after
		s_d.ack = req & ~s_q.ack;
		if (req & ~s_q.ack) begin
			s_d.dat = rd_val;
		end
		if (wr_go) begin
			case (idx)
				`IDX_CHIP_MODE: begin
					s_d.chip_mode = dat_i[7:0] & `MASK_BIT0;
				end
				`IDX_POLL_CTRL: begin
					s_d.poll_ctrl = dat_i[7:0] & `MASK_POLL_CTRL;
				end
				`IDX_REF_DIV: begin
					s_d.ref_div = dat_i[7:0];
				end
				`IDX_OFF_LOW: begin
					s_d.off_low = dat_i[7:0];
				end
				`IDX_OFF_HIGH: begin
					s_d.off_high = dat_i[7:0] & `MASK_OFF_HIGH;
				end
				`IDX_ACT_PER: begin
					s_d.act_per = dat_i[7:0] & `MASK_ACT_PER;
				end
				`IDX_IDLE_PER: begin
					s_d.idle_per = dat_i[7:0];
				end
				`IDX_ON_TIME: begin
					s_d.on_time = dat_i[7:0];
				end
				`IDX_RUN_CTRL: begin
					s_d.run_ctrl = dat_i[7:0] & `MASK_BIT0;
				end
				default: begin
					// Writes to read-only or unmapped words are dropped
				end
			endcase
		end

		// Prescaler and divider run only while polling is enabled; they stay
		// cleared in the stopped phase so the first on window gets full ticks
		if (!poll_run || (s_q.phase == ST_STOP)) begin
			s_d.pre = 6'h00;
			s_d.div_cnt = 9'h000;
		end else begin
			s_d.pre = s_q.pre + 6'h01;
			if (ref_tick) begin
				s_d.div_cnt = 9'h000;
			end else if (tick64) begin
				s_d.div_cnt = s_q.div_cnt + `ONE_9;
			end
		end

		// Period sequencing
		case (s_q.phase)
			ST_STOP: begin
				s_d.rx_on = 1'b0;
				s_d.tmr_cnt = 15'h0000;
				s_d.per_cnt = 9'h000;
				s_d.idle = 1'b0;
				if (poll_run) begin
					// First master period starts active
					s_d.phase = ST_ON;
					s_d.period = 1'b1;
					s_d.rx_on = 1'b1;
				end
			end
			ST_ON: begin
				// Whole on window is timed by the config A on timer
				if (tmr_end) begin
					s_d.phase = ST_OFF;
					s_d.tmr_cnt = 15'h0000;
					s_d.rx_on = 1'b0;
				end else begin
					if (ref_tick) begin
						s_d.tmr_cnt = s_q.tmr_cnt + `ONE_15;
					end
					// End of the channel list depends on the mode
					if (scan_done & s_q.rx_on) begin
						case (mode)
							`MODE_CONST: begin
								// Searching on from config A channel 1
								if (perm_search_en) begin
									s_d.restart = 1'b1;
								end
							end
							`MODE_FAST: begin
								// Falls asleep early; timer keeps going
								s_d.rx_on = 1'b0;
							end
							`MODE_MIXED: begin
								// Only the config B part falls back fast
								if (scan_cfg_b) begin
									s_d.rx_on = 1'b0;
								end
							end
							default: begin
								// Reserved code behaves as constant mode without permanent search: no restart
							end
						endcase
					end
				end
			end
			ST_OFF: begin
				if (tmr_end) begin
					// Master period over: a new one begins
					s_d.phase = ST_ON;
					s_d.tmr_cnt = 15'h0000;
					s_d.period = 1'b1;
					s_d.rx_on = 1'b1;
					if (active_idle_en) begin
						if ((s_q.per_cnt + `ONE_9) == (s_q.idle ? idle_len : act_len)) begin
							s_d.per_cnt = 9'h000;
							s_d.idle = ~s_q.idle;
							s_d.rx_on = s_q.idle;
						end else begin
							s_d.per_cnt = s_q.per_cnt + `ONE_9;
							s_d.rx_on = ~s_q.idle;
						end
					end else begin
						s_d.per_cnt = 9'h000;
						s_d.idle = 1'b0;
					end
				end else if (ref_tick) begin
					s_d.tmr_cnt = s_q.tmr_cnt + `ONE_15;
				end
			end
			default: begin
				s_d.phase = ST_STOP;
			end
		endcase

		// Stopping polling parks the scheduler at once
		if (!poll_run) begin
			s_d.phase = ST_STOP;
			s_d.rx_on = 1'b0;
		end

		// Shared pin carries receiver activity or received data
		s_d.pin = run_pin_function_sel ? rx_data : s_d.rx_on;
	end

	// State register; reset loads constants only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q.phase <= ST_STOP;
			s_q.pre <= 6'h00;
			s_q.div_cnt <= 9'h000;
			s_q.tmr_cnt <= 15'h0000;
			s_q.per_cnt <= 9'h000;
			s_q.idle <= 1'b0;
			s_q.rx_on <= 1'b0;
			s_q.restart <= 1'b0;
			s_q.period <= 1'b0;
			s_q.pin <= 1'b0;
			s_q.chip_mode <= `RST_CHIP_MODE;
			s_q.poll_ctrl <= `RST_POLL_CTRL;
			s_q.ref_div <= `RST_REF_DIV;
			s_q.off_low <= `RST_OFF_LOW;
			s_q.off_high <= `RST_OFF_HIGH;
			s_q.act_per <= `RST_ACT_PER;
			s_q.idle_per <= `RST_IDLE_PER;
			s_q.on_time <= `RST_ON_TIME;
			s_q.run_ctrl <= `RST_RUN_CTRL;
			s_q.ack <= 1'b0;
			s_q.dat <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		dat_o = s_q.dat;
		ack_o = s_q.ack;
		rx_active = s_q.rx_on;
		rx_run_pin = s_q.pin;
		scan_restart = s_q.restart;
		period_start = s_q.period;
		idle_phase = s_q.idle;
	end
endmodule

// file: core/sps_params.svh
// Constants for the self-polling scheduler: offsets, reset values, fields, counts
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CHIP_MODE 6'h03
`define IDX_POLL_CTRL 6'h07
`define IDX_REF_DIV 6'h08
`define IDX_OFF_LOW 6'h09
`define IDX_OFF_HIGH 6'h0a
`define IDX_ACT_PER 6'h0b
`define IDX_IDLE_PER 6'h0c
`define IDX_ON_TIME 6'h0d
`define IDX_RUN_CTRL 6'h0e
`define IDX_STATUS 6'h0f

// Reset values
`define RST_CHIP_MODE 8'h00
`define RST_POLL_CTRL 8'h00
`define RST_REF_DIV 8'h01
`define RST_OFF_LOW 8'h01
`define RST_OFF_HIGH 8'h00
`define RST_ACT_PER 8'h01
`define RST_IDLE_PER 8'h01
`define RST_ON_TIME 8'h01
`define RST_RUN_CTRL 8'h00

// Field positions and writable masks
`define BIT_PERM_SEARCH 3
`define BIT_ACT_IDLE 2
`define BIT_PIN_SEL 0
`define BIT_RUN 0
`define MASK_OFF_HIGH 8'h3f
`define MASK_ACT_PER 8'h1f
`define MASK_POLL_CTRL 8'h0f
`define MASK_BIT0 8'h01

// Polling mode codes
`define MODE_CONST 2'h0
`define MODE_FAST 2'h1
`define MODE_MIXED 2'h2

// Timing counts
`define PRESCALE_LAST 6'h3f
`define LEN_ZERO_8 9'h100
`define LEN_ZERO_OFF 15'h4000
`define ONE_9 9'h001
`define ONE_15 15'h0001
`endif

// file: core/sps_pkg.sv
// Types of the self-polling scheduler
`include "sps_params.svh"
package sps_pkg;
	// Stopped phase and the on and off phases of a master period
	typedef enum logic [1:0] {ST_STOP, ST_ON, ST_OFF} phase_e;

	// Whole state of the scheduler
	typedef struct packed {
		phase_e phase;
		logic [5:0] pre;
		logic [8:0] div_cnt;
		logic [14:0] tmr_cnt;
		logic [8:0] per_cnt;
		logic idle;
		logic rx_on;
		logic restart;
		logic period;
		logic pin;
		logic [7:0] chip_mode;
		logic [7:0] poll_ctrl;
		logic [7:0] ref_div;
		logic [7:0] off_low;
		logic [7:0] off_high;
		logic [7:0] act_per;
		logic [7:0] idle_per;
		logic [7:0] on_time;
		logic [7:0] run_ctrl;
		logic ack;
		logic [31:0] dat;
	} sched_s;
endpackage

// file: verification/scan_engine_model.sv
// Scan engine and external amplifier stand-in
`timescale 1ns/1ps
module scan_engine_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// From the scheduler
	input wire logic rx_active,
	input wire logic rx_run_pin,
	// Bench control
	input wire logic cfg_b_en,
	// To the scheduler, and amplifier state for the bench
	output logic scan_done,
	output logic scan_cfg_b,
	output logic lna_on
);
	logic [5:0] cnt_q; // Receiving cycles in this scan
	// Scan of all channels ends after 40 cycles; shorter than one tick so drops show
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 6'h00;
			scan_done <= 1'b0;
		end else begin
			scan_done <= rx_active && cnt_q == 6'h27;
			cnt_q <= (!rx_active || cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
		end
	end
	// Configuration B is a level held by the bench
	assign scan_cfg_b = cfg_b_en;
	// Amplifier powered while the pin is high
	assign lna_on = rx_run_pin;
endmodule

// file: verification/sps_properties.sv
// Port-level checker of the self-polling scheduler
`timescale 1ns/1ps
module sps_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register bus handshake
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Scheduler side
	input wire logic scan_done,
	input wire logic rx_data,
	input wire logic rx_active,
	input wire logic rx_run_pin,
	input wire logic scan_restart,
	input wire logic period_start,
	input wire logic idle_phase
);
	// All checks live in the single clock domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_ACK_RESP: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("acknowledge held too long");
	AST_PSTART_PULSE: assert property (period_start |=> !period_start)
		else $error("period start longer than one cycle");
	AST_ON_AT_START: assert property ($rose(rx_active) |-> period_start)
		else $error("receiver turned on outside a period start");
	AST_START_ON: assert property (period_start && !idle_phase |-> rx_active)
		else $error("active period began without receiver");
	AST_IDLE_QUIET: assert property (idle_phase |-> !rx_active)
		else $error("receiver on in idle period");
	AST_RESTART_CAUSE: assert property (scan_restart |-> $past(scan_done) && $past(rx_active))
		else $error("scan restart without scan end");
	AST_PIN_FUNC: assert property (rx_run_pin == rx_active || rx_run_pin == $past(rx_data)
		|| rx_run_pin == $past(rx_active))
		else $error("pin shows neither function");
	// Main scenarios reached
	C_ON: cover property ($rose(rx_active));
	C_RESTART: cover property (scan_restart);
	C_IDLE: cover property (idle_phase);
endmodule
bind self_polling_scheduler sps_properties i_sps_properties (.clk(clk), .rstn(rstn),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .scan_done(scan_done), .rx_data(rx_data),
	.rx_active(rx_active), .rx_run_pin(rx_run_pin), .scan_restart(scan_restart),
	.period_start(period_start), .idle_phase(idle_phase));

// file: verification/tb_top.sv
// Self-checking bench of the self-polling scheduler
`timescale 1ns/1ps
`include "sps_params.svh"
module tb_top;
	`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
		$display("ERROR %s exp %0h got %0h", n, e, g); end end
	logic clk = 0, rstn = 0, cyc_i = 0, stb_i = 0, we_i = 0, rx_data = 0, cfg_b_en = 0;
	logic [7:0] adr_i = 0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 0, dat_o;
	logic ack_o, scan_done, scan_cfg_b, rx_active, rx_run_pin, scan_restart, period_start;
	logic idle_phase, lna_on;
	int n_mismatch = 0, n_checks = 0;
	// Register index and reset value table
	logic [5:0] ri [9] = '{`IDX_CHIP_MODE, `IDX_POLL_CTRL, `IDX_REF_DIV, `IDX_OFF_LOW,
		`IDX_OFF_HIGH, `IDX_ACT_PER, `IDX_IDLE_PER, `IDX_ON_TIME, `IDX_RUN_CTRL};
	logic [7:0] rv [9] = '{`RST_CHIP_MODE, `RST_POLL_CTRL, `RST_REF_DIV, `RST_OFF_LOW,
		`RST_OFF_HIGH, `RST_ACT_PER, `RST_IDLE_PER, `RST_ON_TIME, `RST_RUN_CTRL};
	// Divider, off low, off high, control, flags (bit2 short, bit1 restart, bit0 config B)
	logic [7:0] cfg [6][5] = '{'{8'h01, 8'h03, 8'h00, 8'h00, 8'h00},
		'{8'h02, 8'h03, 8'h00, 8'h01, 8'h04}, '{8'h01, 8'h00, 8'h01, 8'h08, 8'h02},
		'{8'h00, 8'h01, 8'h00, 8'h02, 8'h05}, '{8'h01, 8'h03, 8'h00, 8'h02, 8'h00},
		'{8'h01, 8'h03, 8'h00, 8'h03, 8'h00}};
	always #12.5 clk = ~clk;
	self_polling_scheduler i_self_polling_scheduler (.clk(clk), .rstn(rstn), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .scan_done(scan_done), .scan_cfg_b(scan_cfg_b), .rx_data(rx_data),
		.rx_active(rx_active), .rx_run_pin(rx_run_pin), .scan_restart(scan_restart),
		.period_start(period_start), .idle_phase(idle_phase));
	scan_engine_model i_scan_engine_model (.clk(clk), .rstn(rstn), .rx_active(rx_active),
		.rx_run_pin(rx_run_pin), .cfg_b_en(cfg_b_en), .scan_done(scan_done),
		.scan_cfg_b(scan_cfg_b), .lna_on(lna_on));
	// Classic single cycle; holds until ack, then one idle cycle
	task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
		output logic [7:0] q);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= {i, 2'b00}; dat_i <= {24'h0, d};
		do @(posedge clk); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
		@(posedge clk);
	endtask
	// Length of one master period with receiver-on and restart counts
	task automatic period(output int len, output int on, output int rs);
		len = 0; on = 0; rs = 0;
		while (period_start !== 1'b1) @(posedge clk);
		do begin
			on += (rx_active === 1'b1);
			rs += (scan_restart === 1'b1);
			@(posedge clk);
			len++;
		end while (period_start !== 1'b1 && len < 70000);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard, well beyond the planned run
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
	// Test sequence
	initial begin
		logic [7:0] q;
		logic p;
		int len, on, rs, dl, ol;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		foreach (ri[i]) begin wb(0, ri[i], 0, q); `CHK("reset", rv[i], q) end
		wb(0, 6'h01, 0, q); `CHK("unmapped", 8'h00, q)
		wb(1, `IDX_ACT_PER, 8'hff, q); wb(0, `IDX_ACT_PER, 0, q); `CHK("act", 8'h1f, q)
		wb(1, `IDX_OFF_HIGH, 8'hff, q); wb(0, `IDX_OFF_HIGH, 0, q); `CHK("offh", 8'h3f, q)
		wb(1, `IDX_ACT_PER, 8'h01, q);
		// Mode, divider and off-time table
		foreach (cfg[i]) begin
			wb(1, `IDX_RUN_CTRL, 0, q);
			wb(1, `IDX_REF_DIV, cfg[i][0], q);
			wb(1, `IDX_OFF_LOW, cfg[i][1], q);
			wb(1, `IDX_OFF_HIGH, cfg[i][2], q);
			wb(1, `IDX_POLL_CTRL, cfg[i][3], q);
			cfg_b_en <= cfg[i][4][0];
			wb(1, `IDX_RUN_CTRL, 1, q);
			period(len, on, rs);
			dl = cfg[i][0] == 0 ? 256 : cfg[i][0];
			ol = {cfg[i][2][5:0], cfg[i][1]};
			if (ol == 0) ol = 16384;
			`CHK("period", 64 * dl * (1 + ol), len)
			if (cfg[i][4][2]) `CHK("short", 1'b1, on < 64 * dl)
			else `CHK("on", 64 * dl, on)
			`CHK("restart", cfg[i][4][1], rs > 0)
			`CHK("lna", rx_active, lna_on)
		end
		// Two active periods (field masked to 2) then one idle
		wb(1, `IDX_RUN_CTRL, 0, q);
		wb(1, `IDX_REF_DIV, 1, q);
		wb(1, `IDX_ACT_PER, 8'h22, q);
		wb(1, `IDX_POLL_CTRL, 8'h04, q);
		wb(1, `IDX_RUN_CTRL, 1, q);
		for (int k = 0; k < 6; k++) begin
			period(len, on, rs);
			`CHK("active", k % 3 != 2, on > 0)
			`CHK("idle", k % 3 == 1, idle_phase)
		end
		// Pin carries received data one clock late
		wb(1, `IDX_CHIP_MODE, 1, q);
		for (int k = 0; k < 6; k++) begin
			p = rx_data;
			rx_data <= ~rx_data;
			@(posedge clk);
			`CHK("pin", p, rx_run_pin)
		end
		summarize();
	end
endmodule
